// File: rtl/aqpa_arbiter.sv
// Purpose: Picks which of two command queues drives the single converter
// Assumes: Triggers are one-cycle pulses synchronous to clock
// Notes:   Sequencer reports each command end with pause and end flags
//
// How it works
// - Completion flag set when a queue reaches its end condition.
// - Pause flag set when a command with pause bit finishes, unless that command also ends the queue.
// - Trigger during unfinished service sets that queue's overrun flag.
// - Premature trigger is dropped, execution in progress untouched.
// - Extra triggers flag overrun; first trigger after completion restarts.
// - With subqueues, premature triggers flag overrun, execution continues.
// - Second queue trigger during first queue is pending, starts afterwards.
// - Repeated second queue triggers flag overrun, first queue undisturbed.
// - First queue trigger aborts second queue conversion and suspends it.
// - Resume select 0: suspended second queue restarts at first command.
// - Resume select 1: suspended second queue continues at aborted command.
// - Trigger while second queue suspended sets its overrun flag.
// - Freeze lets the running conversion finish, no abort.
// - After freeze, execution resumes with the next command.
// - Triggers during freeze are not captured.
// - Pending second queue trigger survives freeze, acted on afterwards.
// - Second queue suspended across freeze resumes when first queue ends.
// - Four-bit code reports combined condition of both queues.
// - Codes 0011 and 0111 are brief transitions, except that freeze holds them until it drops.
// - Trigger sources are merged outside; one pulse per queue.
// - Simultaneous triggers: first queue runs, second becomes pending.
// - After a pause command the queue waits paused for a trigger.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module aqpa_arbiter (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        trig1,
    input  wire logic                        trig2,
    input  wire logic                        freeze,
    input  wire logic                        cmd_done,
    input  wire logic                        cmd_pause,
    input  wire logic                        cmd_eoq,
    output logic                             cmd_start,
    output logic                             cmd_abort,
    output logic                             cmd_queue,
    output logic [5:0]                       cmd_index,
    input  wire logic [aqpa_pkg::ADDR_W-1:0] addr,
    input  wire logic [aqpa_pkg::DATA_W-1:0] wr_data,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic [aqpa_pkg::DATA_W-1:0]      rd_data
);
    import aqpa_pkg::*;

    logic              t1_r;
    logic              t2_r;
    logic              frz_r;
    aqpa_qstate_t      q1_r;
    aqpa_qstate_t      q1_nxt;
    aqpa_qstate_t      q2_r;
    aqpa_qstate_t      q2_nxt;
    logic [5:0]        idx1_r;
    logic [5:0]        idx1_nxt;
    logic [5:0]        idx2_r;
    logic [5:0]        idx2_nxt;
    logic              busy_r;
    logic              busy_nxt;
    logic              own_r;
    logic [FLG_W-1:0]  flags_r;
    logic [FLG_W-1:0]  flags_set;
    logic [FLG_W-1:0]  flags_clr;
    logic              resume_r;
    logic [5:0]        base_r;
    logic [3:0]        code_w;
    logic [DATA_W-1:0] rd_mux;

    // merged trigger capture
    // Triggers and freeze registered once so every decision sees one clean cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            t1_r  <= 1'b0;
            t2_r  <= 1'b0;
            frz_r <= 1'b0;
        end else begin
            t1_r  <= trig1;
            t2_r  <= trig2;
            frz_r <= freeze;
        end
    end

    // Command end decode for the queue that owns the converter
    wire done1  = cmd_done & busy_r & ~own_r;
    wire done2  = cmd_done & busy_r & own_r;
    wire end1   = done1 & cmd_eoq;
    wire end2   = done2 & cmd_eoq;
    // End of queue wins over a pause in the same command
    wire pause1 = done1 & cmd_pause & ~cmd_eoq;
    wire pause2 = done2 & cmd_pause & ~cmd_eoq;

    wire take1  = t1_r & ~frz_r;
    wire take2  = t2_r & ~frz_r;
    wire ready1 = (q1_r == AQPA_IDLE) | (q1_r == AQPA_PAUSED);
    wire ready2 = (q2_r == AQPA_IDLE) | (q2_r == AQPA_PAUSED);
    wire go1    = take1 & ready1;
    wire go2    = take2 & ready2;
    // overrun on busy queue, trigger dropped
    wire ovr1   = take1 & ~ready1;
    // suspended or pending also counts as busy
    wire ovr2   = take2 & ~ready2;
    wire preempt   = go1 & (q2_r == AQPA_ACTIVE);
    wire abort_now = preempt & busy_r & own_r & ~cmd_done;
    wire q1_hold   = (q1_nxt == AQPA_ACTIVE);
    wire wake2     = ((q2_r == AQPA_PENDING) | (q2_r == AQPA_SUSP))
                     & ~q1_hold & ~frz_r;

    wire can_start = ~busy_r & ~frz_r;
    wire start1    = can_start & (q1_r == AQPA_ACTIVE);
    wire start2    = can_start & ~start1 & ~go1
                     & (q2_r == AQPA_ACTIVE) & (q1_r != AQPA_ACTIVE);

    // First queue next condition
    always_comb begin
        q1_nxt   = q1_r;
        idx1_nxt = idx1_r;
        if (end1) begin
            q1_nxt   = AQPA_IDLE;
            idx1_nxt = Q1_FIRST_IDX;
        end else if (pause1) begin
            q1_nxt   = AQPA_PAUSED;
            idx1_nxt = idx1_r + 6'h01;
        end else if (done1) begin
            idx1_nxt = idx1_r + 6'h01;
        end
        if (go1) begin
            q1_nxt = AQPA_ACTIVE;
            if (q1_r == AQPA_IDLE) begin
                idx1_nxt = Q1_FIRST_IDX;
            end
        end
    end

    // Second queue next condition
    always_comb begin
        q2_nxt   = q2_r;
        idx2_nxt = idx2_r;
        if (end2) begin
            q2_nxt   = AQPA_IDLE;
        end else if (pause2) begin
            q2_nxt   = AQPA_PAUSED;
            idx2_nxt = idx2_r + 6'h01;
        end else if (done2) begin
            idx2_nxt = idx2_r + 6'h01;
        end
        if (preempt && q2_nxt == AQPA_ACTIVE) begin
            q2_nxt = AQPA_SUSP;
        end
        // hold trigger while first queue runs
        if (go2) begin
            q2_nxt = q1_hold ? AQPA_PENDING : AQPA_ACTIVE;
            if (q2_r == AQPA_IDLE) begin
                idx2_nxt = base_r;
            end
        end
        // wake once first queue is done
        if (wake2) begin
            q2_nxt = AQPA_ACTIVE;
            if (q2_r == AQPA_SUSP && !resume_r) begin
                idx2_nxt = base_r;
            end
        end
    end

    // Converter ownership; abort frees it at once
    always_comb begin
        busy_nxt = busy_r;
        if (start1 || start2) begin
            busy_nxt = 1'b1;
        end else if (cmd_done || abort_now) begin
            busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q1_r   <= AQPA_IDLE;
            q2_r   <= AQPA_IDLE;
            idx1_r <= Q1_FIRST_IDX;
            idx2_r <= BASE_RST;
            busy_r <= 1'b0;
        end else begin
            q1_r   <= q1_nxt;
            q2_r   <= q2_nxt;
            idx1_r <= idx1_nxt;
            idx2_r <= idx2_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Command issue towards the sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            own_r     <= 1'b0;
            cmd_start <= 1'b0;
            cmd_abort <= 1'b0;
            cmd_queue <= 1'b0;
            cmd_index <= Q1_FIRST_IDX;
        end else begin
            cmd_start <= start1 | start2;
            cmd_abort <= abort_now;
            if (start1 || start2) begin
                own_r     <= start2;
                cmd_queue <= start2;
                cmd_index <= start1 ? idx1_r : idx2_r;
            end
        end
    end

    // Sticky flags; a set in the clearing cycle survives
    assign flags_set[FLG_CMP1] = end1;
    assign flags_set[FLG_PAU1] = pause1;
    assign flags_set[FLG_OVR1] = ovr1;
    assign flags_set[FLG_CMP2] = end2;
    assign flags_set[FLG_PAU2] = pause2;
    assign flags_set[FLG_OVR2] = ovr2;
    wire wr_ctrl  = wr_en & (addr == OFS_CTRL);
    wire wr_flags = wr_en & (addr == OFS_FLAGS);
    assign flags_clr = wr_flags ? wr_data[FLG_W-1:0] : FLAGS_RST;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flags_r  <= FLAGS_RST;
            resume_r <= RESUME_RST;
            base_r   <= BASE_RST;
        end else begin
            flags_r <= (flags_r & ~flags_clr) | flags_set;
            if (wr_ctrl) begin
                resume_r <= wr_data[CTRL_RESUME_BIT];
                base_r   <= wr_data[CTRL_BASE_LSB +: 6];
            end
        end
    end

    // combined status code
    // Suspended without an active first queue is a one-cycle hand back while not frozen
    always_comb begin
        code_w = QS_II;
        case (q1_r)
            AQPA_IDLE: begin
                case (q2_r)
                    AQPA_IDLE:   code_w = QS_II;
                    AQPA_PAUSED: code_w = QS_IP;
                    AQPA_ACTIVE: code_w = QS_IA;
                    default:     code_w = QS_IT;
                endcase
            end
            AQPA_PAUSED: begin
                case (q2_r)
                    AQPA_IDLE:   code_w = QS_PI;
                    AQPA_PAUSED: code_w = QS_PP;
                    AQPA_ACTIVE: code_w = QS_PA;
                    default:     code_w = QS_PT;
                endcase
            end
            default: begin
                case (q2_r)
                    AQPA_IDLE:   code_w = QS_AI;
                    AQPA_PAUSED: code_w = QS_AP;
                    AQPA_SUSP:   code_w = QS_AS;
                    default:     code_w = QS_AT;
                endcase
            end
        endcase
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        case (addr)
            OFS_CTRL: begin
                rd_mux[CTRL_RESUME_BIT]      = resume_r;
                rd_mux[CTRL_BASE_LSB +: 6]   = base_r;
            end
            OFS_FLAGS: begin
                rd_mux[FLG_W-1:0]            = flags_r;
            end
            OFS_STATUS: begin
                rd_mux[STS_CODE_LSB +: 4]    = code_w;
                rd_mux[STS_Q1_LSB +: 3]      = q1_r;
                rd_mux[STS_Q2_LSB +: 3]      = q2_r;
                rd_mux[STS_BUSY_BIT]         = busy_r;
            end
            default: rd_mux = '0;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_en ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence seq_preempt;
        go1 && q2_r == AQPA_ACTIVE && busy_r && own_r && !cmd_done;
    endsequence
    sequence seq_suspended_abort;
        cmd_abort && q2_r == AQPA_SUSP && !busy_r;
    endsequence

    AST_CMP1: assert property (end1 |=> flags_r[FLG_CMP1] &&
        q1_r == AQPA_IDLE) else $error("completion flag not set");
    AST_PAU2: assert property (pause2 && !preempt |=>
        flags_r[FLG_PAU2] && q2_r == AQPA_PAUSED)
        else $error("pause flag or paused state missing");
    AST_OVR1: assert property (take1 && q1_r == AQPA_ACTIVE |=>
        flags_r[FLG_OVR1]) else $error("overrun flag not set");
    AST_KEEP1: assert property (take1 && q1_r == AQPA_ACTIVE
        && !done1 |=> q1_r == AQPA_ACTIVE && $stable(idx1_r))
        else $error("premature trigger disturbed queue");
    AST_PEND: assert property (take2 && q2_r == AQPA_IDLE
        && q1_r == AQPA_ACTIVE && !done1 |=> q2_r == AQPA_PENDING)
        else $error("second queue trigger not held pending");
    AST_ABORT: assert property (seq_preempt |=>
        seq_suspended_abort) else $error("preemption did not abort");
    AST_RES0: assert property (q2_r == AQPA_SUSP && wake2
        && !resume_r |=> q2_r == AQPA_ACTIVE && idx2_r == $past(base_r))
        else $error("restart not at first command");
    AST_RES1: assert property (q2_r == AQPA_SUSP && wake2
        && resume_r |=> q2_r == AQPA_ACTIVE && $stable(idx2_r))
        else $error("resume not at aborted command");
    AST_OVR2: assert property (take2 && q2_r == AQPA_SUSP |=>
        flags_r[FLG_OVR2]) else $error("overrun while suspended lost");
    AST_FRZ: assert property (frz_r |=> !cmd_start && !cmd_abort)
        else $error("command issued or aborted under freeze");
    AST_TRANS: assert property (code_w == QS_IT && !frz_r |=>
        code_w != QS_IT) else $error("transitional code lingered");

endmodule

// File: rtl/aqpa_pkg.sv
// Purpose: Shared constants and types of the two-queue converter arbiter
// Assumes: Plain register port, 32-bit data, byte offsets on word bounds
// Notes:   Status code table is local to this block
package aqpa_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // Control register fields
    localparam int CTRL_RESUME_BIT = 0;
    localparam int CTRL_BASE_LSB   = 8;

    // Flag register bits, write one to clear
    localparam int FLG_CMP1 = 0;
    localparam int FLG_PAU1 = 1;
    localparam int FLG_OVR1 = 2;
    localparam int FLG_CMP2 = 3;
    localparam int FLG_PAU2 = 4;
    localparam int FLG_OVR2 = 5;
    localparam int FLG_W    = 6;

    // Status register fields
    localparam int STS_CODE_LSB = 0;
    localparam int STS_Q1_LSB   = 4;
    localparam int STS_Q2_LSB   = 8;
    localparam int STS_BUSY_BIT = 12;

    // Values after reset
    localparam logic [5:0] Q1_FIRST_IDX = 6'h00;
    localparam logic [5:0] BASE_RST     = 6'h20;
    localparam logic       RESUME_RST   = 1'b0;
    localparam logic [5:0] FLAGS_RST    = 6'h00;

    // Combined queue status codes {first queue, second queue}
    localparam logic [3:0] QS_II = 4'h0;
    localparam logic [3:0] QS_IP = 4'h1;
    localparam logic [3:0] QS_IA = 4'h2;
    localparam logic [3:0] QS_IT = 4'h3;
    localparam logic [3:0] QS_PI = 4'h4;
    localparam logic [3:0] QS_PP = 4'h5;
    localparam logic [3:0] QS_PA = 4'h6;
    localparam logic [3:0] QS_PT = 4'h7;
    localparam logic [3:0] QS_AI = 4'h8;
    localparam logic [3:0] QS_AP = 4'h9;
    localparam logic [3:0] QS_AS = 4'hA;
    localparam logic [3:0] QS_AT = 4'hB;

    // Condition of one queue
    typedef enum logic [2:0] {
        AQPA_IDLE    = 3'b000,
        AQPA_ACTIVE  = 3'b001,
        AQPA_PAUSED  = 3'b010,
        AQPA_PENDING = 3'b011,
        AQPA_SUSP    = 3'b100
    } aqpa_qstate_t;

endpackage

// File: sim/aqpa_seq_model.sv
// Purpose: Sequencer stand-in facing the queue arbiter
// Assumes: First queue at words 0..3, second at 0x20..0x23
// Notes:   Pause on the second word of a queue when asked
`timescale 1ns/100ps
module aqpa_seq_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       cmd_start,
    input  wire logic       cmd_abort,
    input  wire logic       cmd_queue,
    input  wire logic [5:0] cmd_index,
    input  wire logic       slow,
    input  wire logic       use_pause,
    output logic            cmd_done,
    output logic            cmd_pause,
    output logic            cmd_eoq
);
    logic       busy_r;
    logic       junk_r;
    logic [3:0] cnt_r;
    logic [5:0] ofs_r;

    // Conversion timer; marks carry junk outside the done cycle
    always_ff @(posedge clock) begin
        cmd_done  <= 1'b0;
        junk_r    <= ~junk_r;
        cmd_pause <= junk_r;
        cmd_eoq   <= ~junk_r;
        if (!rst_n) begin
            busy_r <= 1'b0;
            junk_r <= 1'b0;
        end else if (cmd_abort) begin
            busy_r <= 1'b0;
        end else if (cmd_start) begin
            busy_r <= 1'b1;
            cnt_r  <= slow ? 4'h7 : 4'h2;
            ofs_r  <= cmd_queue ? cmd_index - 6'h20 : cmd_index;
        end else if (busy_r && cnt_r == 4'h0) begin
            busy_r    <= 1'b0;
            cmd_done  <= 1'b1;
            cmd_eoq   <= (ofs_r == 6'h03);
            cmd_pause <= use_pause && (ofs_r == 6'h01);
        end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the two-queue arbiter
// Assumes: Sequencer model answers every start that is not aborted
// Notes:   Expected start order is kept in a queue
`timescale 1ns/100ps
module tb_top;
    import aqpa_pkg::*;

    logic        clock;
    logic        rst_n;
    logic        trig1;
    logic        trig2;
    logic        freeze;
    logic        slow;
    logic        use_pause;
    logic        cmd_done;
    logic        cmd_pause;
    logic        cmd_eoq;
    logic        cmd_start;
    logic        cmd_abort;
    logic        cmd_queue;
    logic [5:0]  cmd_index;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic [31:0] rv;
    logic [31:0] lfsr;
    int          num_errors;
    int          compares;
    int          n_start;
    int          n_abort;
    int          n_done;
    int          snap;
    int          snap2;
    int          exp_q[$];

    // System clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    aqpa_arbiter uut (.clock, .rst_n, .trig1, .trig2, .freeze, .cmd_done,
        .cmd_pause, .cmd_eoq, .cmd_start, .cmd_abort, .cmd_queue,
        .cmd_index, .addr, .wr_data, .wr_en, .rd_en, .rd_data);
    aqpa_seq_model seq (.clock, .rst_n, .cmd_start, .cmd_abort, .cmd_queue,
        .cmd_index, .slow, .use_pause, .cmd_done, .cmd_pause, .cmd_eoq);

    // Comparison and bus helpers
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [31:0] nxt(input logic [31:0] l);
        return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
    endfunction

    function automatic logic [31:0] st(input logic [3:0] c,
                                       input logic [2:0] a,
                                       input logic [2:0] b);
        return {21'h0, b, 1'b0, a, c};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        rv = rd_data;
        chk(nm, e, rv & m);
    endtask

    task automatic pulse(input logic a, input logic b);
        @(posedge clock);
        trig1 <= a;
        trig2 <= b;
        @(posedge clock);
        trig1 <= 1'b0;
        trig2 <= 1'b0;
    endtask

    task automatic expq(input int q, input int lo, input int hi);
        for (int i = lo; i <= hi; i++)
            exp_q.push_back(q * 64 + i);
    endtask

    task automatic wait_start(input logic [5:0] ix);
        for (int i = 0; i < 400 && !(cmd_start && cmd_index == ix); i++)
            @(negedge clock);
    endtask

    task automatic wait_done;
        for (int i = 0; i < 2000 && exp_q.size() != 0; i++)
            @(negedge clock);
        repeat (14) @(posedge clock);
    endtask

    task automatic wrap_up;
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Every start is matched against the expected order
    always @(posedge clock) begin
        if (rst_n && cmd_start === 1'b1) begin
            n_start++;
            if (exp_q.size() == 0)
                chk("start", 32'hFFFF,
                    {cmd_queue, cmd_index});
            else
                chk("start", exp_q.pop_front(),
                    {cmd_queue, cmd_index});
        end
        if (cmd_abort === 1'b1)
            n_abort++;
        if (cmd_done === 1'b1)
            n_done++;
    end

    // Hang guard, well past the expected run length
    initial begin
        #(50 * 20000);
        num_errors++;
        wrap_up;
    end

    // Main sequence
    initial begin
        {rst_n, trig1, trig2, freeze, wr_en, rd_en, slow, use_pause} = '0;
        {addr, wr_data, num_errors, compares, n_start, n_abort} = '0;
        n_done = 0;
        lfsr = 32'h0001_6AAF;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rchk("ctrl", OFS_CTRL, '1,
             {18'h0, BASE_RST, 7'h00, RESUME_RST});
        rchk("flags", OFS_FLAGS, '1, {26'h0, FLAGS_RST});
        rchk("status", OFS_STATUS, '1, 32'h0);
        lfsr = nxt(lfsr);
        wr(8'h0C, lfsr);
        rchk("unmapped", 8'h0C, '1, 32'h0);
        // Overruns during a full pass, then restart
        slow <= lfsr[0];
        expq(0, 0, 3);
        pulse(1, 0);
        wait_start(6'h01);
        pulse(1, 0);
        pulse(1, 0);
        wait_done;
        rchk("flags", OFS_FLAGS, '1, 32'h05);
        expq(0, 0, 3);
        pulse(1, 0);
        wait_done;
        wr(OFS_FLAGS, 32'h3F);
        rchk("flags", OFS_FLAGS, '1, 32'h00);
        wr(OFS_FLAGS, 32'h3F);
        // Subqueues with a premature trigger
        use_pause <= 1'b1;
        expq(0, 0, 1);
        pulse(1, 0);
        wait_start(6'h00);
        pulse(1, 0);
        wait_done;
        rchk("status", OFS_STATUS, 32'h7FF, st(QS_PI, AQPA_PAUSED, 0));
        rchk("flags", OFS_FLAGS, '1, 32'h06);
        // Second queue runs while the first is paused, then pauses too
        expq(1, 6'h20, 6'h21);
        pulse(0, 1);
        wait_done;
        rchk("status", OFS_STATUS, 32'h7FF,
             st(QS_PP, AQPA_PAUSED, AQPA_PAUSED));
        expq(0, 2, 3);
        expq(1, 6'h22, 6'h23);
        pulse(1, 1);
        wait_done;
        rchk("flags", OFS_FLAGS, '1, 32'h1F);
        wr(OFS_FLAGS, 32'h3F);
        use_pause <= 1'b0;
        // Simultaneous triggers, then second queue overruns
        lfsr = nxt(lfsr);
        slow <= lfsr[0];
        expq(0, 0, 3);
        expq(1, 6'h20, 6'h23);
        pulse(1, 1);
        rchk("status", OFS_STATUS, 32'h7FF, st(QS_AT, 1, 3));
        pulse(0, 1);
        pulse(0, 1);
        wait_done;
        rchk("flags", OFS_FLAGS, '1, 32'h29);
        wr(OFS_FLAGS, 32'h3F);
        // Pre-emption with both restart points
        slow <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            wr(OFS_CTRL, {18'h0, BASE_RST, 7'h00, r[0]});
            snap = n_abort;
            expq(1, 6'h20, 6'h21);
            expq(0, 0, 3);
            expq(1, r ? 6'h21 : 6'h20, 6'h23);
            pulse(0, 1);
            wait_start(6'h21);
            pulse(1, 0);
            repeat (2) @(posedge clock);
            rchk("status", OFS_STATUS, 32'h7FF, st(QS_AS, 1, 4));
            pulse(0, 1);
            if (r) begin
                freeze <= 1'b1;
                repeat (10) @(posedge clock);
                freeze <= 1'b0;
            end
            wait_done;
            chk("aborts", 32'h1, n_abort - snap);
            rchk("flags", OFS_FLAGS, '1, 32'h29);
            wr(OFS_FLAGS, 32'h3F);
        end
        // Freeze over the last first queue command with a pending trigger
        wr(OFS_CTRL, {18'h0, BASE_RST, 8'h00});
        expq(0, 0, 3);
        expq(1, 6'h20, 6'h23);
        pulse(1, 0);
        wait_start(6'h03);
        pulse(0, 1);
        freeze <= 1'b1;
        snap = n_done;
        snap2 = n_start;
        repeat (12) @(posedge clock);
        chk("done", snap + 1, n_done);
        rchk("status", OFS_STATUS, 32'h7FF,
             st(QS_IT, AQPA_IDLE, AQPA_PENDING));
        pulse(1, 1);
        repeat (6) @(posedge clock);
        chk("frozen", snap2, n_start);
        freeze <= 1'b0;
        wait_done;
        rchk("flags", OFS_FLAGS, '1, 32'h09);
        chk("left", 32'h0, exp_q.size());
        wrap_up;
    end
endmodule
